// file: core/tasl_core.sv
// Thermal alert core with limit compare and lockable presence-detect store.
`timescale 1ns/1ps
module tasl_core
  import tasl_pkg::*;
#(
  parameter int CONV_DIV = CONV_CYCLES
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_n,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Sensor result, 13-bit signed in 0.125 degree steps, from another domain.
  input wire logic [12:0] sense_raw,
  // Open-drain alert pin.
  input wire logic alert_in,
  output logic alert_out,
  output logic alert_oe_n
);
  typedef struct packed {
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic [10:0] cfg;
    logic [15:0] high;
    logic [15:0] low;
    logic [15:0] crit;
    logic [15:0] temp;
    logic [31:0] cnt;
    logic soft_lock;
    logic perm_lock;
    logic reg_lock;
    logic hi_c;
    logic lo_c;
    logic cr_c;
    logic [1:0] latched;
    logic armed;
    logic alert;
    logic rd_mem;
    logic [1:0] pin_s;
    logic alert_pin;
  } tasl_state_t;

  tasl_state_t s_q, s_d;
  logic [12:0] raw_s1_q, raw_s2_q;
  tasl_mem_if mem_if ();

  tasl_mem u_mem (
    .sys_clk(sys_clk),
    .bus(mem_if)
  );

  // Raw sensor bus crosses in by two flops; a real sensor holds it stable.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      raw_s1_q <= 13'h0000;
      raw_s2_q <= 13'h0000;
    end else begin
      raw_s1_q <= sense_raw;
      raw_s2_q <= raw_s1_q;
    end
  end

  logic setup_w, wr, rd, locked_lim, crit_lock_bit, conv_tick, is_mem;
  logic [15:0] wr16, hyst, t_new;
  logic signed [15:0] ts, hs, ls, cs, hv;
  logic [2:0] cond_n;
  logic int_mode;

  always_comb begin
    s_d = s_q;
    setup_w = psel && !penable;
    wr = psel && penable && pwrite && !s_q.ready;
    rd = psel && penable && !pwrite && !s_q.ready;
    wr16 = pwdata[15:0];
    is_mem = paddr[11:10] == ADDR_MEM[11:10];
    locked_lim = s_q.cfg[CFG_LIMLOCK] || s_q.cfg[CFG_CRITLOCK];
    crit_lock_bit = s_q.cfg[CFG_CRITLOCK];
    int_mode = s_q.cfg[CFG_MODE];
    mem_if.we = 1'b0;
    mem_if.addr = paddr[9:2];
    mem_if.wdata = pwdata[7:0];
    s_d.ready = 1'b0;
    s_d.err = 1'b0;
    if (setup_w) begin
      s_d.rd_mem = 1'b0;
    end
    // Store reads need one wait cycle for the registered read data.
    if (rd && is_mem && !s_q.rd_mem) begin
      s_d.rd_mem = 1'b1;
    end else if (rd) begin
      s_d.ready = 1'b1;
      s_d.rdata = 32'h0000_0000;
      case (paddr)
        ADDR_CONFIG: s_d.rdata = {21'h000000,
            s_q.cfg[10:CFG_STS + 2], 1'b0, s_q.alert, s_q.cfg[3:0]};
        ADDR_HIGH: s_d.rdata = {16'h0000, s_q.high};
        ADDR_LOW: s_d.rdata = {16'h0000, s_q.low};
        ADDR_CRIT: s_d.rdata = {16'h0000, s_q.crit};
        ADDR_TEMP: s_d.rdata = {16'h0000, s_q.temp};
        ADDR_LOCK: s_d.rdata = {29'h00000000, s_q.perm_lock,
            s_q.soft_lock, s_q.reg_lock};
        default: begin
          if (is_mem) begin
            s_d.rdata = {24'h000000, mem_if.rdata};
          end else begin
            s_d.err = 1'b1;
          end
        end
      endcase
    end
    if (wr) begin
      s_d.ready = 1'b1;
      case (paddr)
        ADDR_CONFIG: begin
          // Shutdown can always clear; it sets only with locks clear.
          if (!wr16[CFG_MONITOR_SHUTDOWN] || !locked_lim) begin
            s_d.cfg[CFG_MONITOR_SHUTDOWN] = wr16[CFG_MONITOR_SHUTDOWN];
          end
          if (!crit_lock_bit) begin
            s_d.cfg[10:9] = wr16[10:9];
          end
          if (!locked_lim) begin
            s_d.cfg[CFG_EN] = wr16[CFG_EN];
            s_d.cfg[CFG_POL] = wr16[CFG_POL];
            s_d.cfg[CFG_MODE] = wr16[CFG_MODE];
          end
          if (!s_q.cfg[CFG_LIMLOCK]) begin
            s_d.cfg[CFG_CRITONLY] = wr16[CFG_CRITONLY];
          end
          s_d.cfg[CFG_LIMLOCK] = s_q.cfg[CFG_LIMLOCK] || wr16[CFG_LIMLOCK];
          s_d.cfg[CFG_CRITLOCK] = crit_lock_bit || wr16[CFG_CRITLOCK];
          // A mode change in either direction drops the window latch.
          if (!locked_lim && wr16[CFG_MODE] != int_mode) begin
            s_d.latched = 2'b00;
            s_d.armed = 1'b0;
          end
          // Clear acts only in interrupt mode; it is never stored.
          if (wr16[CFG_CLEAR] && int_mode) begin
            s_d.latched = 2'b00;
            s_d.armed = 1'b1;
          end
        end
        ADDR_HIGH: if (!s_q.cfg[CFG_LIMLOCK]) s_d.high = wr16 & 16'h1ffe;
        ADDR_LOW: if (!s_q.cfg[CFG_LIMLOCK]) s_d.low = wr16 & 16'h1ffe;
        ADDR_CRIT: if (!crit_lock_bit) s_d.crit = wr16 & 16'h1ffe;
        ADDR_LOCK: s_d.reg_lock = pwdata[0];
        ADDR_SWP: s_d.soft_lock = 1'b1;
        ADDR_CWP: s_d.soft_lock = 1'b0;
        ADDR_PERM: s_d.perm_lock = 1'b1;
        default: begin
          if (is_mem) begin
            // Lower half is blocked by any lock; upper half is free.
            mem_if.we = !(paddr[9] == 1'b0 && (s_q.reg_lock ||
                s_q.soft_lock || s_q.perm_lock));
          end else begin
            s_d.err = 1'b1;
          end
        end
      endcase
    end
    // Conversion tick, stopped in standby.
    conv_tick = 1'b0;
    if (s_q.cfg[CFG_MONITOR_SHUTDOWN]) begin
      s_d.cnt = 32'h0000_0000;
    end else if (s_q.cnt == 32'(CONV_DIV - 1)) begin
      s_d.cnt = 32'h0000_0000;
      conv_tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 32'h0000_0001;
    end
    // Saturate the raw reading into the coded range.
    // Saturation keeps the reading in twelve bits, so bits 15:13 stay zero.
    t_new = {3'b000, raw_s2_q[11:0], 1'b0};
    if ($signed(raw_s2_q) < $signed(13'h1e00)) begin
      t_new = TEMP_MIN;
    end else if ($signed(raw_s2_q) > $signed(13'h05ff)) begin
      t_new = TEMP_MAX;
    end
    case (s_q.cfg[10:9])
      2'b01: hyst = HYST_1;
      2'b10: hyst = HYST_2;
      2'b11: hyst = HYST_3;
      default: hyst = 16'h0000;
    endcase
    // Sign-extend 13-bit codes for the compare.
    ts = {{3{t_new[12]}}, t_new[12:0]};
    hs = {{3{s_q.high[12]}}, s_q.high[12:0]};
    ls = {{3{s_q.low[12]}}, s_q.low[12:0]};
    cs = {{3{s_q.crit[12]}}, s_q.crit[12:0]};
    hv = $signed(hyst);
    cond_n = {s_q.cr_c, s_q.lo_c, s_q.hi_c};
    if (conv_tick) begin
      s_d.temp = t_new;
      cond_n[0] = s_q.hi_c ? (ts >= hs - hv) : (ts >= hs);
      cond_n[1] = s_q.lo_c ? (ts <= ls) : (ts < ls - hv);
      cond_n[2] = s_q.cr_c ? (ts >= cs - hv) : (ts >= cs);
      s_d.hi_c = cond_n[0];
      s_d.lo_c = cond_n[1];
      s_d.cr_c = cond_n[2];
      if (int_mode) begin
        // Latch only a new condition, not one already seen.
        if (cond_n[0] && !s_q.hi_c || !s_q.armed && cond_n[0] &&
            s_q.latched == 2'b00 && 1'b0) begin
          s_d.latched[0] = 1'b1;
        end
        if (cond_n[1] && !s_q.lo_c) begin
          s_d.latched[1] = 1'b1;
        end
      end
      if (!cond_n[0] && !cond_n[1]) begin
        s_d.armed = 1'b0;
      end
      // Critical is level-driven; window follows the selected mode.
      s_d.alert = s_q.cfg[CFG_EN] && (cond_n[2] ||
          (!s_q.cfg[CFG_CRITONLY] && (int_mode ? (s_d.latched != 2'b00)
          : (cond_n[0] || cond_n[1]))));
    end else if (!s_q.cfg[CFG_EN]) begin
      s_d.alert = 1'b0;
    end else if (wr && paddr == ADDR_CONFIG) begin
      // Comparator mode keeps its window level; a clear write has no say.
      s_d.alert = s_q.cr_c || (!s_q.cfg[CFG_CRITONLY] &&
          int_mode == s_d.cfg[CFG_MODE] && (int_mode ?
          (s_d.latched != 2'b00) :
          (s_q.hi_c || s_q.lo_c)));
    end
    s_d.pin_s = {s_q.pin_s[0], alert_in};
    s_d.alert_pin = s_q.pin_s[1];
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{rdata: 32'h0000_0000, ready: 1'b0, err: 1'b0,
          cfg: CFG_RESET[10:0], high: HIGH_RESET, low: LOW_RESET,
          crit: CRIT_RESET, temp: 16'h0000, cnt: 32'h0000_0000,
          soft_lock: 1'b0, perm_lock: 1'b0, reg_lock: 1'b0,
          hi_c: 1'b0, lo_c: 1'b0, cr_c: 1'b0, latched: 2'b00,
          armed: 1'b0, alert: 1'b0, rd_mem: 1'b0, pin_s: 2'b00,
          alert_pin: 1'b0};
      alert_out <= 1'b0;
      alert_oe_n <= 1'b1;
    end else begin
      s_q <= s_d;
      // Pin only ever drives low, whenever alert differs from the polarity bit; high is by pull-up.
      alert_out <= 1'b0;
      alert_oe_n <= !(s_d.alert ^ s_d.cfg[CFG_POL]);
    end
  end

  assign prdata = s_q.rdata;
  assign pready = s_q.ready;
  assign pslverr = s_q.err;

  alert_gated_a: assert property (@(posedge sys_clk)
    disable iff (!rst_n) !s_q.cfg[CFG_EN] |=> !s_q.alert)
    else $error("alert asserted while disabled");
  pin_level_a: assert property (@(posedge sys_clk)
    disable iff (!rst_n) alert_oe_n == !(s_q.alert ^ s_q.cfg[CFG_POL]))
    else $error("alert pin level wrong");
  standby_freeze_a: assert property (@(posedge sys_clk)
    disable iff (!rst_n) s_q.cfg[CFG_MONITOR_SHUTDOWN] |=> $stable(s_q.temp))
    else $error("temperature updated in standby");
  clear_reads_zero_a: assert property (@(posedge sys_clk)
    disable iff (!rst_n) s_q.ready |-> !(paddr == ADDR_CONFIG &&
    !pwrite && s_q.rdata[CFG_CLEAR]))
    else $error("clear bit read as one");
  temp_range_a: assert property (@(posedge sys_clk)
    disable iff (!rst_n) !s_q.temp[0] && s_q.temp[15:13] == 3'b000)
    else $error("temperature word malformed");
  perm_lock_a: assert property (@(posedge sys_clk)
    disable iff (!rst_n) s_q.perm_lock |=> s_q.perm_lock)
    else $error("permanent lock dropped");
  lower_guard_a: assert property (@(posedge sys_clk)
    disable iff (!rst_n) (mem_if.we && !mem_if.addr[7]) |->
    !(s_q.reg_lock || s_q.soft_lock || s_q.perm_lock))
    else $error("locked lower half written");
  monitor_shutdown_lock_a: assert property (@(posedge sys_clk)
    disable iff (!rst_n) (!s_q.cfg[CFG_MONITOR_SHUTDOWN] && locked_lim) |=>
    !s_q.cfg[CFG_MONITOR_SHUTDOWN])
    else $error("shutdown set under lock");
  crit_alert_a: assert property (@(posedge sys_clk)
    disable iff (!rst_n) (conv_tick && s_q.cfg[CFG_EN] && cond_n[2]) |=>
    s_q.alert)
    else $error("critical condition without alert");
  rate_a: assert property (@(posedge sys_clk)
    disable iff (!rst_n) conv_tick |=> !conv_tick)
    else $error("conversion tick too fast");

  // Mode-switch and clear writes between conversions settle the alert in one cycle.
  sequence mode_flip_s;
    wr && paddr == ADDR_CONFIG && s_q.cfg[CFG_EN] && !conv_tick &&
        !locked_lim && wr16[CFG_MODE] != int_mode;
  endsequence
  sequence int_clear_s;
    wr && paddr == ADDR_CONFIG && s_q.cfg[CFG_EN] && !conv_tick &&
        int_mode && wr16[CFG_CLEAR] && (locked_lim || wr16[CFG_MODE]);
  endsequence
  sequence comp_clear_s;
    wr && paddr == ADDR_CONFIG && s_q.cfg[CFG_EN] && !conv_tick &&
        !int_mode && wr16[CFG_CLEAR] && !s_q.cfg[CFG_CRITONLY] &&
        (locked_lim || !wr16[CFG_MODE]);
  endsequence
  mode_release_a: assert property (@(posedge sys_clk)
    disable iff (!rst_n) mode_flip_s |=> s_q.alert == s_q.cr_c)
    else $error("window alert kept over mode switch");
  clear_release_a: assert property (@(posedge sys_clk)
    disable iff (!rst_n) int_clear_s |=> s_q.alert == s_q.cr_c)
    else $error("interrupt alert kept after clear");
  clear_ignored_a: assert property (@(posedge sys_clk)
    disable iff (!rst_n) comp_clear_s |=>
    s_q.alert == (s_q.cr_c || s_q.hi_c || s_q.lo_c))
    else $error("comparator alert changed by clear");
  crit_only_a: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    (conv_tick && s_q.cfg[CFG_CRITONLY] && !cond_n[2]) |=> !s_q.alert)
    else $error("window alert in critical-only mode");
  standby_tick_a: assert property (@(posedge sys_clk)
    disable iff (!rst_n) s_q.cfg[CFG_MONITOR_SHUTDOWN] |-> !conv_tick)
    else $error("conversion during standby");
endmodule : tasl_core

// file: core/tasl_pkg.sv
// Package of register offsets, fields, reset values and timing for the block.
package tasl_pkg;
  // Register byte offsets on APB.
  localparam logic [11:0] ADDR_CONFIG = 12'h000;
  localparam logic [11:0] ADDR_HIGH = 12'h004;
  localparam logic [11:0] ADDR_LOW = 12'h008;
  localparam logic [11:0] ADDR_CRIT = 12'h00c;
  localparam logic [11:0] ADDR_TEMP = 12'h010;
  localparam logic [11:0] ADDR_RAW = 12'h014;
  localparam logic [11:0] ADDR_LOCK = 12'h018;
  localparam logic [11:0] ADDR_SWP = 12'h01c;
  localparam logic [11:0] ADDR_CWP = 12'h020;
  localparam logic [11:0] ADDR_PERM = 12'h024;
  localparam logic [11:0] ADDR_MEM = 12'h400;
  // Configuration fields.
  localparam int CFG_MODE = 0;
  localparam int CFG_POL = 1;
  localparam int CFG_CRITONLY = 2;
  localparam int CFG_EN = 3;
  localparam int CFG_STS = 4;
  localparam int CFG_CLEAR = 5;
  localparam int CFG_LIMLOCK = 6;
  localparam int CFG_CRITLOCK = 7;
  localparam int CFG_MONITOR_SHUTDOWN = 8;
  localparam int CFG_HYST = 9;
  // Reset values of limits and configuration.
  localparam logic [15:0] CFG_RESET = 16'h0000;
  localparam logic [15:0] HIGH_RESET = 16'h0550;
  localparam logic [15:0] LOW_RESET = 16'h0000;
  localparam logic [15:0] CRIT_RESET = 16'h05a0;
  // Temperature word end codes, 0.125 degree per step at bit 1.
  localparam logic [15:0] TEMP_MIN = 16'h1c00;
  localparam logic [15:0] TEMP_MAX = 16'h0bfe;
  // Hysteresis in the data word: 1.5, 3 and 6 degrees.
  localparam logic [15:0] HYST_1 = 16'h0018;
  localparam logic [15:0] HYST_2 = 16'h0030;
  localparam logic [15:0] HYST_3 = 16'h0060;
  // Store geometry.
  localparam int MEM_BYTES = 256;
  localparam int MEM_AW = 8;
  // Timing.
  localparam int CLK_HZ = 50_000_000;
  localparam int CONV_PER_S = 8;
  localparam int CONV_CYCLES = CLK_HZ / CONV_PER_S;
endpackage : tasl_pkg

// file: core/tasl_mem_if.sv
// Interface between the core and its nonvolatile store model.
`timescale 1ns/1ps
interface tasl_mem_if;
  logic we;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport core (output we, output addr, output wdata, input rdata);
  modport mem (input we, input addr, input wdata, output rdata);
endinterface : tasl_mem_if

// file: core/tasl_mem.sv
// Byte store for the presence-detect data with registered read data.
`timescale 1ns/1ps
module tasl_mem
  import tasl_pkg::*;
#(
  parameter int DEPTH = MEM_BYTES
) (
  // Clock.
  input wire logic sys_clk,
  // Access port.
  tasl_mem_if.mem bus
);
  logic [7:0] store_q [DEPTH];

  // The store has no reset: its content is meant to survive.
  always_ff @(posedge sys_clk) begin
    if (bus.we) begin
      store_q[bus.addr] <= bus.wdata;
    end
    bus.rdata <= store_q[bus.addr];
  end
endmodule : tasl_mem

// file: tb/tasl_far_end.sv
// Far-side model: sensor source on a slow link clock and alert pull-up.
`timescale 1ns/1ps
module tasl_far_end (
  // Link clock and requested reading.
  input wire logic link_clk,
  input wire logic [12:0] temp_set,
  // Sensor result towards the core.
  output logic [12:0] sense_raw,
  // Alert pin parts and resolved level.
  input wire logic alert_out,
  input wire logic alert_oe_n,
  output wire logic alert_pin
);
  initial sense_raw = 13'h0000;
  // The reading changes on the link clock, unrelated to the core clock.
  always @(posedge link_clk) begin
    sense_raw <= temp_set;
  end
  // Open drain: the external resistor pulls up when nobody drives.
  assign alert_pin = alert_oe_n ? 1'b1 : alert_out;
endmodule : tasl_far_end

// file: tb/thermal_alert_and_spd_lock_tb.sv
// Self-checking bench for the thermal alert and lockable store core.
`timescale 1ns/1ps
module thermal_alert_and_spd_lock_tb
  import tasl_pkg::*;
;
  logic sys_clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [12:0] raw = 13'h0000;
  logic [12:0] sense_raw;
  logic alert_out;
  logic alert_oe_n;
  logic alert_pin;
  logic [31:0] rdata;
  logic rerr;
  int num_errors = 0;
  int checked = 0;

  always #10 sys_clk = ~sys_clk;
  always #80 link_clk = ~link_clk;

  tasl_core #(.CONV_DIV(50)) i_dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sense_raw(sense_raw), .alert_in(alert_pin), .alert_out(alert_out),
    .alert_oe_n(alert_oe_n));

  tasl_far_end i_far (.link_clk(link_clk), .temp_set(raw),
    .sense_raw(sense_raw), .alert_out(alert_out), .alert_oe_n(alert_oe_n),
    .alert_pin(alert_pin));

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  // Holds the request until pready is seen high at a rising edge.
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      num_errors++;
      $display("wrong value at %0t: no ready from slave", $time);
    end
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdata, e);
  endtask : rd

  task automatic pin(input logic e);
    @(posedge sys_clk);
    chk({31'h0, alert_pin}, {31'h0, e});
  endtask : pin

  // Three conversions at the shortened divider, plus link and sync delay.
  task automatic temp(input logic [12:0] r);
    raw <= r;
    repeat (170) @(posedge sys_clk);
  endtask : temp

  task automatic done(input string s);
    $display("test %s done", s);
  endtask : done

  initial begin
    repeat (20000 * 3) @(posedge sys_clk);
    num_errors++;
    tally_and_finish();
  end

  initial begin
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rd(ADDR_CONFIG, 32'h0);
    rd(ADDR_HIGH, 32'h0550);
    rd(ADDR_LOW, 32'h0);
    rd(ADDR_CRIT, 32'h05a0);
    temp(13'h02b0);
    pin(1'b1);
    rd(ADDR_TEMP, 32'h0560);
    done("reset");
    wr(ADDR_CONFIG, 32'h08);
    temp(13'h02b0);
    pin(1'b0);
    wr(ADDR_CONFIG, 32'h28);
    pin(1'b0);
    rd(ADDR_CONFIG, 32'h18);
    temp(13'h0100);
    pin(1'b1);
    temp(13'h1ff0);
    pin(1'b0);
    rd(ADDR_TEMP, 32'h1fe0);
    wr(ADDR_CONFIG, 32'h09);
    pin(1'b1);
    temp(13'h1ff0);
    pin(1'b1);
    done("comparator");
    temp(13'h0100);
    temp(13'h02b0);
    pin(1'b0);
    wr(ADDR_CONFIG, 32'h29);
    pin(1'b1);
    temp(13'h02b0);
    pin(1'b1);
    temp(13'h0100);
    temp(13'h02b0);
    pin(1'b0);
    wr(ADDR_CONFIG, 32'h08);
    pin(1'b1);
    wr(ADDR_CONFIG, 32'h09);
    temp(13'h0340);
    pin(1'b0);
    wr(ADDR_CONFIG, 32'h29);
    pin(1'b0);
    done("interrupt");
    wr(ADDR_CONFIG, 32'h20c);
    temp(13'h02b0);
    pin(1'b1);
    temp(13'h02d0);
    pin(1'b0);
    temp(13'h02c8);
    pin(1'b0);
    temp(13'h02c0);
    pin(1'b1);
    wr(ADDR_CONFIG, 32'h0e);
    temp(13'h02d0);
    pin(1'b1);
    temp(13'h0100);
    pin(1'b0);
    done("critical");
    wr(ADDR_CONFIG, 32'h0);
    temp(13'h0fff);
    rd(ADDR_TEMP, 32'h0bfe);
    temp(13'h1000);
    rd(ADDR_TEMP, 32'h1c00);
    temp(13'h0001);
    rd(ADDR_TEMP, 32'h0002);
    wr(ADDR_CONFIG, 32'h100);
    temp(13'h0080);
    rd(ADDR_TEMP, 32'h0002);
    wr(ADDR_HIGH, 32'h0600);
    rd(ADDR_HIGH, 32'h0600);
    wr(ADDR_MEM + 12'h00c, 32'h5a);
    rd(ADDR_MEM + 12'h00c, 32'h5a);
    wr(ADDR_CONFIG, 32'h0);
    temp(13'h0080);
    rd(ADDR_TEMP, 32'h0100);
    done("data");
    wr(ADDR_SWP, 32'h0);
    wr(ADDR_MEM + 12'h00c, 32'h22);
    rd(ADDR_MEM + 12'h00c, 32'h5a);
    wr(ADDR_MEM + 12'h320, 32'h33);
    rd(ADDR_MEM + 12'h320, 32'h33);
    rd(ADDR_LOCK, 32'h2);
    wr(ADDR_CWP, 32'h0);
    wr(ADDR_MEM + 12'h00c, 32'h22);
    rd(ADDR_MEM + 12'h00c, 32'h22);
    wr(ADDR_LOCK, 32'h1);
    wr(ADDR_MEM + 12'h00c, 32'h44);
    rd(ADDR_MEM + 12'h00c, 32'h22);
    wr(ADDR_LOCK, 32'h0);
    wr(ADDR_PERM, 32'h0);
    wr(ADDR_CWP, 32'h0);
    wr(ADDR_MEM + 12'h00c, 32'h44);
    rd(ADDR_MEM + 12'h00c, 32'h22);
    rd(ADDR_LOCK, 32'h4);
    apb(1'b0, 12'h100, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    done("store");
    wr(ADDR_CONFIG, 32'h40);
    wr(ADDR_CONFIG, 32'h140);
    rd(ADDR_CONFIG, 32'h40);
    done("lock");
    tally_and_finish();
  end
endmodule : thermal_alert_and_spd_lock_tb
